// >>> rtl/tsic_top.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "tsic_cfg.svh"

// What this block does
// RULE_01 - Software keeps bits 15-14 at zero
// RULE_02 - Loop enable ignored in master mode
// RULE_03 - Enabled loop: outputs from input, locked upper
// RULE_04 - Two-bit field picks master or slave
// RULE_05 - Loopback from output two, ignored in slave
// RULE_06 - Software sets rate 00 under loopback
// RULE_07 - Position bit: straddle or start at boundary
// RULE_08 - Edge bit: falling low, rising high
// RULE_09 - Frame pulse polarity selects detection level
// RULE_10 - Rate field: 16M, 8M, 4M, reserved
// RULE_11 - Register reads back written fields
module tsic_top
    import tsic_pkg::*;
(
    input  wire logic        clk,                 // System clock, 25 MHz
    input  wire logic        rst_n,               // Async reset, active low
    input  wire logic [3:0]  address,             // Avalon byte address
    input  wire logic        read,                // Avalon read
    input  wire logic        write,               // Avalon write
    input  wire logic [3:0]  byteenable,          // Avalon byte enables
    input  wire logic [31:0] writedata,           // Avalon write data
    output logic [31:0]      readdata,            // Avalon read data
    output logic             waitrequest,         // Avalon wait request
    input  wire logic        oscillator_enable,   // Oscillator enabled
    input  wire logic        input_timing_clock,  // Link clock
    input  wire logic        input_frame_pulse,   // External frame pulse
    input  wire logic        loop_frame_pulse,    // Output frame pulse two
    output logic             slave_mode,          // Slave operation
    output logic             phase_locked_loop,   // Loop running
    output logic             output_clocks_slaved, // Lower outputs from input
    output logic             loopback_active,     // Input taken from outputs
    output logic             frame_locked,        // Frame length matches rate
    output logic [7:0]       frame_count          // Frames seen, wraps
);

    ////////////////////////////////////////////////////////////////////////
    // Main domain

    tsic_main_s m;
    tsic_main_s next_m;
    tsic_link_s l;
    tsic_link_s next_l;
    logic       fp_neg;
    logic       hit_ctrl;
    logic       hit_stat;
    logic [1:0] opm;
    logic       is_slave;

    assign hit_ctrl = (address == `TSIC_ADDR_CTRL);
    assign hit_stat = (address == `TSIC_ADDR_STAT);
    assign opm      = m.ctrl[`TSIC_B_OPM_HI:`TSIC_B_OPM_LO];
    assign is_slave = (opm == `TSIC_OPM_SLAVE); // RULE_04

    // One wait state, released in DONE
    assign waitrequest = (read || write) && (m.bus != TSIC_BUS_DONE);

    always_comb begin
        next_m = m;
        case (m.bus)
            TSIC_BUS_IDLE: begin
                if (read || write) begin
                    next_m.bus   = TSIC_BUS_DONE;
                    next_m.rdata = 16'h0000;
                    if (hit_ctrl) begin
                        next_m.rdata = {2'h0, m.ctrl}; // RULE_11 RULE_01
                    end else if (hit_stat) begin
                        next_m.rdata[`TSIC_S_LOCK]     = m.lock;
                        next_m.rdata[`TSIC_S_LOOP]     = m.loop_en;
                        next_m.rdata[`TSIC_S_LOOPBACK] = m.loopback_act;
                        next_m.rdata[`TSIC_S_SLAVE]    = m.slave_mode;
                        next_m.rdata[`TSIC_CTRL_BYTE_HI:`TSIC_S_CNT_LO] = m.frame_cnt;
                    end
                end
            end
            TSIC_BUS_DONE: begin
                next_m.bus = TSIC_BUS_IDLE;
                if (write && hit_ctrl) begin
                    if (byteenable[0]) begin
                        next_m.ctrl[`TSIC_CTRL_LOW_HI:0] = writedata[`TSIC_CTRL_LOW_HI:0]; // RULE_11
                    end
                    if (byteenable[1]) begin
                        next_m.ctrl[`TSIC_CTRL_HI:`TSIC_CTRL_BYTE_LO] =
                            writedata[`TSIC_CTRL_HI:`TSIC_CTRL_BYTE_LO];
                    end
                end
            end
            default: begin
                next_m.bus = TSIC_BUS_IDLE;
            end
        endcase

        // Decoded operating levels
        next_m.slave_mode   = is_slave; // RULE_04
        next_m.loop_en      = is_slave && m.ctrl[`TSIC_B_LOOP_EN] && oscillator_enable; // RULE_02
        next_m.loopback_act = !is_slave && m.ctrl[`TSIC_B_LOOPBACK]; // RULE_05

        // Frame event toggle and lock level from link domain
        next_m.ev_sync   = {m.ev_sync[1:0], l.ev_tgl};
        next_m.lock_sync = {m.lock_sync[1:0], l.lock};
        if (m.ev_sync[1] == m.ev_sync[2]) begin
            next_m.ev_acc = m.ev_sync[2];
            if (m.ev_sync[2] != m.ev_acc) begin
                next_m.frame_cnt = m.frame_cnt + 8'h01;
            end
        end
        if (m.lock_sync[1] == m.lock_sync[2]) begin
            next_m.lock = m.lock_sync[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m <= '0;
        end else begin
            m <= next_m;
        end
    end

    assign readdata             = {16'h0000, m.rdata};
    assign slave_mode           = m.slave_mode;
    assign phase_locked_loop    = m.loop_en;
    assign output_clocks_slaved = m.loop_en; // RULE_03
    assign loopback_active      = m.loopback_act;
    assign frame_locked         = m.lock;
    assign frame_count          = m.frame_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Link domain

    tsic_cfg_s  cfg_src;
    logic       fp_pos_in;
    logic       fp_sample;
    logic       active;
    logic       boundary;
    logic [11:0] frame_last;
    logic       rate_ok;

    always_comb begin
        cfg_src.loopback = m.loopback_act;
        cfg_src.fp_pos   = m.ctrl[`TSIC_B_FP_POS];
        cfg_src.ck_pol   = m.ctrl[`TSIC_B_CK_POL];
        cfg_src.fp_pol   = m.ctrl[`TSIC_B_FP_POL];
        cfg_src.rate     = m.ctrl[`TSIC_B_RATE_HI:`TSIC_B_RATE_LO];
    end

    // Pulse source: pin or looped output two
    assign fp_pos_in = l.cfg.loopback ? loop_frame_pulse : input_frame_pulse; // RULE_05

    // Falling-edge sample for falling-edge alignment
    always_ff @(negedge input_timing_clock or negedge rst_n) begin
        if (!rst_n) begin
            fp_neg <= 1'b0;
        end else begin
            fp_neg <= fp_pos_in;
        end
    end

    assign fp_sample = l.cfg.ck_pol ? fp_pos_in : fp_neg;           // RULE_08
    assign active    = l.cfg.fp_pol ? fp_sample : !fp_sample;       // RULE_09
    assign boundary  = l.cfg.fp_pos ? l.fp_rise : l.rise_d;         // RULE_07

    always_comb begin
        case (l.cfg.rate)
            `TSIC_RATE_16M: frame_last = `TSIC_CLKS(`TSIC_KHZ_16M); // RULE_10
            `TSIC_RATE_8M:  frame_last = `TSIC_CLKS(`TSIC_KHZ_8M);  // RULE_10
            `TSIC_RATE_4M:  frame_last = `TSIC_CLKS(`TSIC_KHZ_4M);  // RULE_10
            default:        frame_last = 12'h000;
        endcase
    end

    assign rate_ok = (l.cfg.rate != `TSIC_RATE_RSVD); // RULE_10

    always_comb begin
        next_l          = l;
        next_l.cfg_s1   = cfg_src;
        next_l.cfg_s2   = l.cfg_s1;
        next_l.cfg_s3   = l.cfg_s2;
        if (l.cfg_s2 == l.cfg_s3) begin
            next_l.cfg = l.cfg_s3;
        end
        next_l.act_prev = active;
        next_l.fp_rise  = active && !l.act_prev;
        next_l.rise_d   = l.fp_rise;
        if (boundary && rate_ok) begin
            next_l.lock   = (l.cnt == frame_last);
            next_l.cnt    = 12'h000;
            next_l.ev_tgl = !l.ev_tgl;
        end else begin
            if (l.cnt != 12'hfff) begin
                next_l.cnt = l.cnt + 12'h001;
            end
            if (!rate_ok || l.cnt > frame_last) begin
                next_l.lock = 1'b0;
            end
        end
    end

    always_ff @(posedge input_timing_clock or negedge rst_n) begin
        if (!rst_n) begin
            l          <= '0;
            l.act_prev <= 1'b1; // No false pulse edge after reset
        end else begin
            l <= next_l;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    answer_one_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        (read || write) && m.bus == TSIC_BUS_IDLE |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after one wait state");

    ctrl_readback_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        m.bus == TSIC_BUS_DONE && write && hit_ctrl && byteenable[1:0] == 2'h3
        |=> m.ctrl == $past(writedata[13:0]))
        else $error("control write not stored");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        m.bus == TSIC_BUS_DONE && read && hit_ctrl |-> readdata[15:14] == 2'h0)
        else $error("reserved control bits read nonzero");

    master_no_loop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        opm != `TSIC_OPM_SLAVE |=> !phase_locked_loop)
        else $error("loop running in master mode");

    slave_loop_on_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        is_slave && m.ctrl[`TSIC_B_LOOP_EN] && oscillator_enable
        |=> phase_locked_loop && output_clocks_slaved && slave_mode)
        else $error("slave loop not enabled");

    slave_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        $changed(opm) |=> slave_mode == ($past(opm) == `TSIC_OPM_SLAVE))
        else $error("slave mode does not follow field");

    loopback_slave_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        loopback_active |-> $past(m.ctrl[`TSIC_B_LOOPBACK]) && !slave_mode)
        else $error("loopback active without cause");

    rate_reserved_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_10
        l.cfg.rate == `TSIC_RATE_RSVD |=> !l.lock && $stable(l.ev_tgl))
        else $error("frame accepted at reserved rate");

    start_pos_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_07
        l.cfg.fp_pos && rate_ok && $stable(l.cfg) && l.fp_rise |=> l.cnt == 12'h000)
        else $error("frame start not at pulse start");

    polarity_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_09
        l.fp_rise
        |-> $past(fp_sample == l.cfg.fp_pol) && !$past(fp_sample == l.cfg.fp_pol, 2))
        else $error("frame pulse edge at wrong level");

    ////////////////////////////////////////////////////////////////////////
    // Further bus, mode and link checks

    idle_no_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        !read && !write
        |-> !waitrequest)
        else $error("wait request without a request");

    unmapped_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        m.bus == TSIC_BUS_DONE && read && !hit_ctrl && !hit_stat
        |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    ctrl_low_lane_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        m.bus == TSIC_BUS_DONE && write && hit_ctrl && byteenable[0]
        |=> m.ctrl[7:0] == $past(writedata[7:0]))
        else $error("control low byte not stored");

    ctrl_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        !(m.bus == TSIC_BUS_DONE && write && hit_ctrl)
        |=> $stable(m.ctrl))
        else $error("control changed without a write");

    read_ctrl_value_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        m.bus == TSIC_BUS_IDLE && read && hit_ctrl
        |=> readdata == {18'h00000, $past(m.ctrl)})
        else $error("control read not the stored value");

    status_count_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        m.bus == TSIC_BUS_IDLE && read && hit_stat
        |=> readdata[15:8] == $past(frame_count))
        else $error("status read wrong frame count");

    loop_needs_osc_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        !oscillator_enable
        |=> !phase_locked_loop)
        else $error("loop running without oscillator");

    loop_bit_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        !m.ctrl[`TSIC_B_LOOP_EN]
        |=> !phase_locked_loop)
        else $error("loop running with enable low");

    slaved_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        output_clocks_slaved
        |-> slave_mode && $past(oscillator_enable) && $past(m.ctrl[`TSIC_B_LOOP_EN]))
        else $error("outputs slaved without cause");

    upper_opm_master_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        opm[1]
        |=> !slave_mode)
        else $error("upper operation codes not master");

    loopback_ignored_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        slave_mode
        |-> !loopback_active)
        else $error("loopback active in slave mode");

    loopback_on_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        !is_slave && m.ctrl[`TSIC_B_LOOPBACK]
        |=> loopback_active)
        else $error("loopback not taken in master mode");

    frame_step_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        frame_count != $past(frame_count)
        |-> frame_count == $past(frame_count) + 8'h01)
        else $error("frame count jumped");

    straddle_pos_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_07
        !l.cfg.fp_pos && rate_ok && $stable(l.cfg) && l.rise_d
        |=> l.cnt == 12'h000)
        else $error("straddled frame start misplaced");

    rising_pick_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_08
        l.cfg.ck_pol && l.cfg.fp_pol && $stable(l.cfg)
        |=> l.act_prev == $past(fp_pos_in))
        else $error("pulse not taken on rising edge");

    falling_pick_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_08
        !l.cfg.ck_pol && l.cfg.fp_pol && $stable(l.cfg)
        |=> l.act_prev == $past(fp_neg))
        else $error("pulse not taken on falling edge");

    overrun_unlock_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_10
        !boundary && l.cnt > frame_last
        |=> !l.lock)
        else $error("lock kept after frame overrun");

    lock_on_match_a: assert property (@(posedge input_timing_clock) disable iff (!rst_n) // RULE_10
        boundary && rate_ok && l.cnt == frame_last
        |=> l.lock && l.cnt == 12'h000)
        else $error("matching frame not locked");

endmodule

// >>> rtl/tsic_cfg.svh
`ifndef TSIC_CFG_SVH
`define TSIC_CFG_SVH

// Register byte addresses
`define TSIC_ADDR_CTRL     4'h0
`define TSIC_ADDR_STAT     4'h4

// Control register layout
`define TSIC_CTRL_RESET    14'h0000
`define TSIC_B_LOOP_EN     13
`define TSIC_B_OPM_HI      12
`define TSIC_B_OPM_LO      11
`define TSIC_B_LOOPBACK    10
`define TSIC_B_FP_POS      9
`define TSIC_B_CK_POL      8
`define TSIC_B_FP_POL      7
`define TSIC_B_RATE_HI     6
`define TSIC_B_RATE_LO     5
`define TSIC_CTRL_HI       13
`define TSIC_CTRL_BYTE_HI  15
`define TSIC_CTRL_BYTE_LO  8
`define TSIC_CTRL_LOW_HI   7

// Operation select codes
`define TSIC_OPM_MASTER    2'h0
`define TSIC_OPM_SLAVE     2'h1

// Input rate select codes
`define TSIC_RATE_16M      2'h0
`define TSIC_RATE_8M       2'h1
`define TSIC_RATE_4M       2'h2
`define TSIC_RATE_RSVD     2'h3

// Frame timing: frame length in ns, input clock rates in kHz
`define TSIC_FRAME_NS      125000
`define TSIC_KHZ_16M       16384
`define TSIC_KHZ_8M        8192
`define TSIC_KHZ_4M        4096
`define TSIC_CLKS(khz)     (12'((`TSIC_FRAME_NS * (khz)) / 1000000 - 1))

// Status register layout
`define TSIC_S_LOCK        0
`define TSIC_S_LOOP        1
`define TSIC_S_LOOPBACK    2
`define TSIC_S_SLAVE       3
`define TSIC_S_CNT_LO      8

`endif

// >>> rtl/tsic_pkg.sv
package tsic_pkg;

    typedef enum logic [0:0] {
        TSIC_BUS_IDLE = 1'b0,
        TSIC_BUS_DONE = 1'b1
    } tsic_bus_e;

    // Link-side copy of timing settings
    typedef struct packed {
        logic       loopback;
        logic       fp_pos;
        logic       ck_pol;
        logic       fp_pol;
        logic [1:0] rate;
    } tsic_cfg_s;

    typedef struct packed {
        tsic_bus_e  bus;
        logic [13:0] ctrl;
        logic [15:0] rdata;
        logic [2:0] ev_sync;
        logic       ev_acc;
        logic [2:0] lock_sync;
        logic       lock;
        logic [7:0] frame_cnt;
        logic       slave_mode;
        logic       loop_en;
        logic       loopback_act;
    } tsic_main_s;

    typedef struct packed {
        tsic_cfg_s  cfg_s1;
        tsic_cfg_s  cfg_s2;
        tsic_cfg_s  cfg_s3;
        tsic_cfg_s  cfg;
        logic       fp_rise;
        logic       act_prev;
        logic       rise_d;
        logic [11:0] cnt;
        logic       ev_tgl;
        logic       lock;
    } tsic_link_s;

endpackage

// >>> verification/tsic_link_model.sv
`timescale 1ns/10ps
module tsic_link_model (
    input  wire logic        run,          // Link clock enable
    input  wire logic [11:0] len,          // Frame length in link clocks
    input  wire logic        active_high,  // Pulse polarity
    input  wire logic        rise_edge,    // Device samples on rising edge
    input  wire logic        use_loop,     // Real pulse on loop line
    output logic             link_clk,     // Link clock
    output logic             fp_ext,       // External pulse pin
    output logic             fp_loop       // Output frame pulse two
);
    logic [11:0] cnt = 12'h000;
    logic        tog = 1'b0;
    logic        real_fp;

    initial link_clk = 1'b0;
    always #32 if (run) link_clk = ~link_clk;

    // Launch on the edge opposite the sampling edge
    always @(link_clk) begin
        if (link_clk != rise_edge) begin
            cnt <= (cnt >= len - 12'h001) ? 12'h000 : cnt + 12'h001;
            tog <= ~tog;
        end
    end

    assign real_fp = (cnt == 12'h000) ~^ active_high;
    // Unused line toggles so a wrong source cannot lock
    assign fp_ext  = use_loop ? tog : real_fp;
    assign fp_loop = use_loop ? real_fp : ~tog;
endmodule

// >>> verification/test_tsic_top.sv
`timescale 1ns/10ps
`include "tsic_cfg.svh"
module test_tsic_top;
    import tsic_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        osc = 1'b0;
    logic        link_clk, fp_ext, fp_loop;
    logic        slave_mode, pll, slaved, lb_act, locked;
    logic [7:0]  frame_count;
    logic [11:0] len = 12'h800;
    logic        act_hi = 1'b1;
    logic        rise = 1'b1;
    logic        use_loop = 1'b0;
    logic [31:0] lfsr = 32'hf1a3;
    logic [31:0] exp_q[$];
    logic [1:0]  rates[5] = '{`TSIC_RATE_16M, `TSIC_RATE_8M, `TSIC_RATE_4M, `TSIC_RATE_8M, `TSIC_RATE_16M};
    logic [11:0] lens[5]  = '{12'h800, 12'h400, 12'h200, 12'h200, 12'h800};
    logic        locks[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    int          err_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    tsic_top tsic_top_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .byteenable(4'h3), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .oscillator_enable(osc), .input_timing_clock(link_clk), .input_frame_pulse(fp_ext),
        .loop_frame_pulse(fp_loop), .slave_mode(slave_mode), .phase_locked_loop(pll),
        .output_clocks_slaved(slaved), .loopback_active(lb_act), .frame_locked(locked),
        .frame_count(frame_count));
    tsic_link_model tsic_link_model_i (.run(1'b1), .len(len), .active_high(act_hi), .rise_edge(rise),
        .use_loop(use_loop), .link_clk(link_clk), .fp_ext(fp_ext), .fp_loop(fp_loop));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, expv, seen);
        end
    endtask

    // Holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [31:0] expv);
        if (!wr) exp_q.push_back(expv);
        @(posedge clk);
        address   <= a;
        writedata <= {16'h0000, d};
        read      <= !wr;
        write     <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic check_modes(input logic [13:0] v, input logic o);
        logic sl;
        sl = (v[12:11] == `TSIC_OPM_SLAVE);
        repeat (3) @(negedge clk);
        check("slave_mode", slave_mode, sl);
        check("phase_locked_loop", pll, sl & v[13] & o);
        check("output_clocks_slaved", slaved, sl & v[13] & o);
        check("loopback_active", lb_act, v[10] & !sl);
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) begin
            check("readdata", readdata, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 70000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    initial begin
        logic [13:0] v;
        logic [7:0]  fc;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("frame_locked", locked, 1'b0);
        check("slave_mode", slave_mode, 1'b0);
        bus(1'b0, `TSIC_ADDR_CTRL, 16'h0000, 32'h0);
        bus(1'b0, 4'h8, 16'h0000, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr = next_rand(lfsr);
            v = lfsr[13:0];
            v[12:11] = i[1:0];
            osc <= lfsr[20];
            bus(1'b1, `TSIC_ADDR_CTRL, {2'b00, v}, 32'h0);
            bus(1'b1, 4'h8, ~{2'b00, v}, 32'h0);
            bus(1'b1, `TSIC_ADDR_STAT, 16'hffff, 32'h0);
            bus(1'b0, `TSIC_ADDR_CTRL, 16'h0000, {18'h0, v});
            check_modes(v, lfsr[20]);
        end
        // Frame detection per rate, edge and polarity, then loopback
        for (int r = 0; r < 5; r++) begin
            len      <= lens[r];
            use_loop <= (r == 4);
            act_hi   <= r[0];
            rise     <= r[1];
            v = {3'b000, r == 4, !r[1], r[1], r[0], rates[r], 5'h00};
            bus(1'b1, `TSIC_ADDR_CTRL, {2'b00, v}, 32'h0);
            @(negedge clk);
            fc = frame_count;
            for (int k = 0; k < 20000 && 8'(frame_count - fc) < 8'h05; k++) @(negedge clk);
            check("frame_count", 8'(frame_count - fc) >= 8'h05, 1'b1);
            check("frame_locked", locked, locks[r]);
            @(posedge clk);
        end
        give_verdict();
    end
endmodule
